/* File: design/sic_pkg.sv */
package sic_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NSRC = 15;
    localparam int SCFG_W = 8;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_CFG = 10'h003;
    localparam logic [IDX_W-1:0] IDX_SCFG1 = 10'h014;
    localparam logic [IDX_W-1:0] IDX_SCFG15 = 10'h022;
    localparam logic [IDX_W-1:0] IDX_MASK = 10'h036;
    localparam logic [IDX_W-1:0] IDX_PEND = 10'h03a;
    localparam logic [IDX_W-1:0] IDX_WDV = 10'h042;

    // ----------------------------------------------------------------
    // reset values and field layout
    // ----------------------------------------------------------------
    localparam logic [7:0] CFG_RESET = 8'hc0;
    localparam logic [7:0] CFG_MASK = 8'he0;
    localparam int CFG_FRZ_WD_BIT = 7;
    localparam int CFG_FRZ_BM_BIT = 6;
    localparam int CFG_LOCK_BIT = 5;
    localparam logic [15:0] MASK_RESET = 16'h3ffe;
    localparam logic [15:0] MASK_VALID = 16'hfffe;
    localparam logic [7:0] WDV_RESET = 8'h0f;
    // entry 0 (low byte) belongs to source 1
    localparam logic [NSRC*SCFG_W-1:0] SCFG_RESET_FLAT = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h1c,
        8'h1c, 8'h18, 8'h14, 8'h10, 8'h0c, 8'h08, 8'h04};

    // ----------------------------------------------------------------
    // source numbers and fixed values
    // ----------------------------------------------------------------
    localparam int SRC_EXT_LAST = 7;
    localparam int SRC_WDOG = 8;
    localparam int SRC_TMR1 = 9;
    localparam int SRC_TWI = 11;
    localparam logic [2:0] LEVEL_WDOG = 3'h7;
    localparam logic [7:0] AUTOVEC_BASE = 8'h18;
    // external slots 2, 3, 5 and 6 only exist in encoded mode
    localparam logic [15:0] ENC_ONLY_SRCS = 16'h006c;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic auto_vector_on;
        logic [1:0] rsvd;
        logic [2:0] int_level_field;
        logic [1:0] int_priority_field;
    } sic_scfg_s;

    typedef struct packed {
        logic done;
        logic auto;
        logic [3:0] src;
        logic [7:0] vector;
    } sic_ack_s;

    typedef enum logic [1:0] {BUS_IDLE, BUS_OWNED, BUS_LOCKED} sic_bus_e;

    // force the reserved and fixed fields of one source's config byte
    function automatic logic [7:0] sic_fix_scfg(input int src, input logic [7:0] d);
        sic_scfg_s r;
        r = sic_scfg_s'(d);
        r.rsvd = 2'h0;
        if (src <= SRC_EXT_LAST) begin
            r.int_level_field = src[2:0];
        end
        if (src == SRC_WDOG) begin
            r.int_level_field = LEVEL_WDOG;
            r.auto_vector_on = 1'b0;
        end
        if (src >= SRC_TMR1 && src <= SRC_TWI) begin
            r.auto_vector_on = 1'b1;
        end
        return r;
    endfunction

    // autovector number for a level
    function automatic logic [7:0] sic_autovec(input logic [2:0] lvl);
        return AUTOVEC_BASE + {5'h00, lvl};
    endfunction

endpackage

/* File: design/sic_icr_bank.sv */
// small register bank holding the per-source config bytes
module sic_scfg_bank #(
    parameter int N = 15,
    parameter int W = 8,
    parameter logic [N*W-1:0] RESET_FLAT = '0
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [3:0] rd_idx,
    output logic [W-1:0] rd_data,
    output logic [N*W-1:0] all_flat
);

    logic [N*W-1:0] mem_r;

    // each entry resets to its own value
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mem_r <= RESET_FLAT;
        end else if (wr_en && int'(wr_idx) < N) begin
            mem_r[wr_idx*W +: W] <= wr_data;
        end
    end

    // read data is registered; out-of-range index reads zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= (int'(rd_idx) < N) ? mem_r[rd_idx*W +: W] : '0;
        end
    end

    assign all_flat = mem_r;

endmodule

/* File: design/sic_interrupt_config.sv */
// Summary of operation
// - internal freeze follows the core's debug halt mode.
// - reset loads both freeze enables as one and bus lock as zero.
// - watchdog halts during freeze only when its freeze bit is one.
// - bus monitor halts during freeze only when its freeze bit is one.
// - lock off: bus driven drops once grant gone and cycle finished.
// - lock on: bus driven rises with grant, held until lock cleared.
// - one read-write 8-bit config byte per source, own reset value.
// - external levels fixed to their own level; watchdog level fixed at 7.
// - individual external mode ignores config of external levels 2,3,5,6.
// - autovector is level plus 24 during acknowledge.
// - watchdog autovector bit reads zero; vector from watchdog vector register.
// - timers and two-wire unit autovector bit always one.
// - level 7 highest, 1 lowest, 0 means no request.
// - priority 3 highest, 0 lowest, within one level.
// - autovector bit 7, level bits 4..2, priority bits 1..0.
// - mask bit set masks, clear enables.
// - masked sources still set pending, but no request to core.
// - mask bits: externals 1-7, watchdog 8, timers 9-10, two-wire 11, serial, dma.
// - reset sets mask bits 1 to 13; non-reserved bits 14 and 15 reset clear.
//
// Implementation choices: the APB register port and the register offsets.
module sic_interrupt_config
    import sic_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // debug and protection
    input wire logic debug_halt_mode,
    output logic freeze_out,
    output logic watchdog_halt,
    output logic bus_monitor_halt,
    // bus ownership
    input wire logic bus_grant_in,
    input wire logic bus_cycle_busy,
    output logic bus_driven_out,
    // interrupt sources
    input wire logic [7:1] external_request_bits,
    input wire logic ext_individual,
    input wire logic [15:8] internal_request_bits,
    // core side
    output logic [2:0] core_ipl,
    input wire logic iack_req,
    input wire logic [2:0] iack_level,
    output logic iack_done,
    output logic iack_auto,
    output logic [3:0] iack_src,
    output logic [7:0] iack_vector
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0] cfg_r;
    logic [15:0] mask_r;
    logic [15:0] pending_flags;
    logic [7:0] wdv_r;
    logic freeze_r;
    logic wd_halt_r;
    logic bm_halt_r;
    sic_bus_e bus_state_r;
    sic_bus_e bus_state_nxt;
    sic_ack_s ack_r;
    sic_ack_s ack_nxt;
    logic [31:0] prdata_r;
    logic scfg_rd_r;
    logic [SCFG_W-1:0] scfg_rd_data;
    logic [NSRC*SCFG_W-1:0] scfg_flat;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire [IDX_W-1:0] word_idx = paddr[ADDR_W-1:2];
    wire setup_phase = psel && !penable;
    wire access_phase = psel && penable;
    wire hit_cfg = (word_idx == IDX_CFG);
    wire hit_scfg = (word_idx >= IDX_SCFG1) && (word_idx <= IDX_SCFG15);
    wire hit_mask = (word_idx == IDX_MASK);
    wire hit_pend = (word_idx == IDX_PEND);
    wire hit_wdv = (word_idx == IDX_WDV);
    wire hit_any = hit_cfg | hit_scfg | hit_mask | hit_pend | hit_wdv;
    wire [IDX_W-1:0] scfg_off = word_idx - IDX_SCFG1;
    wire [3:0] scfg_idx = scfg_off[3:0];
    wire wr_fire = access_phase && pwrite && hit_any;
    wire wr_low = wr_fire && pstrb[0];
    wire wr_high = wr_fire && pstrb[1];

    // zero-wait slave; unmapped words answer with an error
    assign pready = 1'b1;
    assign pslverr = access_phase && !hit_any;
    assign prdata = scfg_rd_r ? {24'h000000, scfg_rd_data} : prdata_r;

    // ----------------------------------------------------------------
    // read path: data captured in the setup cycle
    // ----------------------------------------------------------------
    wire [31:0] rd_mux =
        hit_cfg ? {24'h000000, cfg_r} :
        hit_mask ? {16'h0000, mask_r} :
        hit_pend ? {16'h0000, pending_flags} :
        hit_wdv ? {24'h000000, wdv_r} : 32'h00000000;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_r <= 32'h00000000;
            scfg_rd_r <= 1'b0;
        end else if (setup_phase) begin
            prdata_r <= rd_mux;
            scfg_rd_r <= hit_scfg && !pwrite;
        end
    end

    // ----------------------------------------------------------------
    // config byte bank
    // ----------------------------------------------------------------
    // fixed fields
    wire [7:0] scfg_wr_data = sic_fix_scfg(int'(scfg_idx) + 1, pwdata[7:0]);

    sic_scfg_bank #(
        .N(NSRC),
        .W(SCFG_W),
        .RESET_FLAT(SCFG_RESET_FLAT)
    ) u_bank (
        .mclk(mclk),
        .reset_n(reset_n),
        .wr_en(wr_low && hit_scfg),
        .wr_idx(scfg_idx),
        .wr_data(scfg_wr_data),
        .rd_en(setup_phase && hit_scfg),
        .rd_idx(scfg_idx),
        .rd_data(scfg_rd_data),
        .all_flat(scfg_flat)
    );

    // ----------------------------------------------------------------
    // configuration, mask and watchdog vector registers
    // ----------------------------------------------------------------
    // reset of freeze and lock bits
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_r <= CFG_RESET;
        end else if (wr_low && hit_cfg) begin
            cfg_r <= pwdata[7:0] & CFG_MASK;
        end
    end

    // mask register, bit n is source n, bit 0 reserved
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mask_r <= MASK_RESET;
        end else if (hit_mask) begin
            if (wr_low) begin
                mask_r[7:0] <= pwdata[7:0] & MASK_VALID[7:0];
            end
            if (wr_high) begin
                mask_r[15:8] <= pwdata[15:8] & MASK_VALID[15:8];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wdv_r <= WDV_RESET;
        end else if (wr_low && hit_wdv) begin
            wdv_r <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // freeze and halt outputs
    // ----------------------------------------------------------------
    // halts follow debug mode and freeze enables
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            freeze_r <= 1'b0;
            wd_halt_r <= 1'b0;
            bm_halt_r <= 1'b0;
        end else begin
            freeze_r <= debug_halt_mode;
            wd_halt_r <= debug_halt_mode && cfg_r[CFG_FRZ_WD_BIT];
            bm_halt_r <= debug_halt_mode && cfg_r[CFG_FRZ_BM_BIT];
        end
    end

    assign freeze_out = freeze_r;
    assign watchdog_halt = wd_halt_r;
    assign bus_monitor_halt = bm_halt_r;

    // ----------------------------------------------------------------
    // bus ownership
    // ----------------------------------------------------------------
    wire bus_lock_ctl = cfg_r[CFG_LOCK_BIT];

    // lock holds ownership through grant loss so no other master can split
    // a locked sequence
    always_comb begin
        bus_state_nxt = bus_state_r;
        case (bus_state_r)
            BUS_IDLE: begin
                if (bus_grant_in) begin
                    bus_state_nxt = bus_lock_ctl ? BUS_LOCKED : BUS_OWNED;
                end
            end
            BUS_OWNED: begin
                if (bus_lock_ctl) begin
                    bus_state_nxt = BUS_LOCKED;
                // release after grant and cycle end
                end else if (!bus_grant_in && !bus_cycle_busy) begin
                    bus_state_nxt = BUS_IDLE;
                end
            end
            BUS_LOCKED: begin
                if (!bus_lock_ctl) begin
                    bus_state_nxt = BUS_OWNED;
                end
            end
            default: bus_state_nxt = BUS_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bus_state_r <= BUS_IDLE;
        end else begin
            bus_state_r <= bus_state_nxt;
        end
    end

    assign bus_driven_out = (bus_state_r != BUS_IDLE);

    // ----------------------------------------------------------------
    // pending capture
    // ----------------------------------------------------------------
    // pending set regardless of mask
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pending_flags <= 16'h0000;
        end else begin
            pending_flags <= {internal_request_bits, external_request_bits, 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    logic [4:0] best_key;
    logic [3:0] best_src;
    logic best_auto_vector_on;

    // scans all sources for the largest level/priority key
    always_comb begin
        sic_scfg_s c;
        logic elig;
        logic [4:0] key;
        best_key = 5'h00;
        best_src = 4'h0;
        best_auto_vector_on = 1'b0;
        c = '0;
        elig = 1'b0;
        key = 5'h00;
        for (int s = 1; s <= NSRC; s++) begin
            c = sic_scfg_s'(scfg_flat[(s-1)*SCFG_W +: SCFG_W]);
            key = {c.int_level_field, c.int_priority_field};
            // masked sources never reach the core
            elig = pending_flags[s] && !mask_r[s] && (c.int_level_field != 3'h0);
            // unused encoded slots in individual mode
            if (ext_individual && ENC_ONLY_SRCS[s]) begin
                elig = 1'b0;
            end
            if (elig && key > best_key) begin
                best_key = key;
                best_src = s[3:0];
                best_auto_vector_on = c.auto_vector_on;
            end
        end
    end

    assign core_ipl = best_key[4:2];

    // ----------------------------------------------------------------
    // interrupt acknowledge
    // ----------------------------------------------------------------
    // answer one cycle after the request; a level with no winner gets
    // the autovector, which stands in for a spurious answer
    always_comb begin
        ack_nxt = '0;
        if (iack_req) begin
            ack_nxt.done = 1'b1;
            if (best_src != 4'h0 && iack_level == core_ipl) begin
                ack_nxt.src = best_src;
                if (int'(best_src) == SRC_WDOG) begin
                    ack_nxt.vector = wdv_r;
                end else if (best_auto_vector_on) begin
                    ack_nxt.auto = 1'b1;
                    ack_nxt.vector = sic_autovec(iack_level);
                end
                // otherwise the source supplies its vector
            end else begin
                ack_nxt.auto = 1'b1;
                ack_nxt.vector = sic_autovec(iack_level);
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r <= '0;
        end else begin
            ack_r <= ack_nxt;
        end
    end

    assign iack_done = ack_r.done;
    assign iack_auto = ack_r.auto;
    assign iack_src = ack_r.src;
    assign iack_vector = ack_r.vector;

endmodule

/* File: tb/sic_interrupt_config_chk.sv */
module sic_chk (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic debug_halt_mode,
    input wire logic freeze_out,
    input wire logic watchdog_halt,
    input wire logic bus_monitor_halt,
    input wire logic bus_grant_in,
    input wire logic bus_driven_out,
    input wire logic iack_req,
    input wire logic [2:0] iack_level,
    input wire logic iack_done,
    input wire logic iack_auto,
    input wire logic [3:0] iack_src,
    input wire logic [7:0] iack_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // properties, all on the one system clock
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // acknowledge taken at one edge, answered at the next
    sequence s_ack;
        iack_req ##1 iack_done;
    endsequence
    a_freeze_follow: assert property (freeze_out == $past(debug_halt_mode))
        else $error("freeze late");
    a_wd_halt_cause: assert property (watchdog_halt |-> $past(debug_halt_mode))
        else $error("watchdog halted outside debug");
    a_bm_halt_cause: assert property (bus_monitor_halt |-> $past(debug_halt_mode))
        else $error("bus monitor halted outside debug");
    a_drive_needs_grant: assert property ($rose(bus_driven_out) |-> $past(bus_grant_in))
        else $error("bus driven without grant");
    a_idle_stays: assert property (!bus_grant_in && !bus_driven_out |=> !bus_driven_out)
        else $error("bus taken while idle");
    a_granted_holds: assert property (bus_driven_out && bus_grant_in |=> bus_driven_out)
        else $error("bus dropped under grant");
    a_ack_answer: assert property (iack_req |-> s_ack)
        else $error("acknowledge not answered");
    a_autovec_sum: assert property (iack_done && iack_auto |->
        iack_vector == 8'h18 + {5'h00, $past(iack_level)})
        else $error("autovector wrong");
    a_timer_auto: assert property (iack_done && iack_src inside {4'h9, 4'ha, 4'hb} |->
        iack_auto)
        else $error("timer ack not autovectored");
    a_wdog_manual: assert property (iack_done && iack_src == 4'h8 |-> !iack_auto)
        else $error("watchdog ack autovectored");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access stalled");
endmodule

bind sic_interrupt_config sic_chk i_sic_chk (.mclk, .reset_n, .psel, .penable, .pready,
    .debug_halt_mode, .freeze_out, .watchdog_halt, .bus_monitor_halt, .bus_grant_in,
    .bus_driven_out, .iack_req, .iack_level, .iack_done, .iack_auto, .iack_src, .iack_vector);

/* File: tb/sic_core_model.sv */
// core side: acknowledges any nonzero level it is shown, once per ack_en pulse
module sic_core_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ack_en,
    input wire logic [2:0] core_ipl,
    output logic iack_req,
    output logic [2:0] iack_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // vector of a non-auto source is the source's business, not modelled
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            iack_req <= 1'b0;
            iack_level <= 3'h0;
        end else begin
            iack_req <= ack_en && core_ipl != 3'h0;
            iack_level <= core_ipl; // level 0 never asks: no request there
        end
    end
endmodule

/* File: tb/sic_interrupt_config_test.sv */
module sic_interrupt_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb, iack_src;
    logic debug_halt_mode, freeze_out, watchdog_halt, bus_monitor_halt;
    logic bus_grant_in, bus_cycle_busy, bus_driven_out, ext_individual;
    logic [7:1] external_request_bits;
    logic [15:8] internal_request_bits;
    logic [2:0] core_ipl, iack_level;
    logic iack_req, iack_done, iack_auto, ack_en;
    logic [7:0] iack_vector, x8;
    int miscompares, n_tests, n;
    logic [7:0] scfg_rst [1:15] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
        8'h1c, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};

    sic_interrupt_config i_sic_interrupt_config (.mclk, .reset_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .debug_halt_mode,
        .freeze_out, .watchdog_halt, .bus_monitor_halt, .bus_grant_in, .bus_cycle_busy,
        .bus_driven_out, .external_request_bits, .ext_individual, .internal_request_bits,
        .core_ipl, .iack_req, .iack_level, .iack_done, .iack_auto, .iack_src, .iack_vector);
    sic_core_model i_sic_core_model (.mclk, .reset_n, .ack_en, .core_ipl, .iack_req,
        .iack_level);

    // ------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until pready seen at an edge; result in q and e
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
        chk(32'(e), 32'h0);
    endtask
    task automatic tk(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask
    // one ack pulse from the core model, then the answer is compared
    task automatic ack(input logic [3:0] s, input logic a, input logic [7:0] v);
        @(posedge mclk) ack_en <= 1'b1;
        @(posedge mclk) ack_en <= 1'b0;
        repeat (8) begin
            if (iack_done !== 1'b1) tk(1);
        end
        chk({19'h0, iack_src, iack_auto, iack_vector}, {19'h0, s, a, v});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, hang guard and test sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // run needs well under a thousand cycles; a hang ends here
    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ack_en} = '0;
        {debug_halt_mode, bus_grant_in, bus_cycle_busy, ext_individual} = '0;
        pstrb = 4'hf;
        external_request_bits = '0;
        internal_request_bits = '0;
        reset_n = 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        rd(12'h00c, 32'hc0);
        for (n = 1; n <= 15; n++) begin
            rd(12'h04c + 12'(4 * n), 32'(scfg_rst[n]));
        end
        rd(12'h0d8, 32'h3ffe);
        rd(12'h108, 32'h0f);
        // unmapped word errors, reads zero
        wr(12'h004, 32'hffffffff);
        chk(32'(e), 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0);
        // all ones: reserved and fixed fields must win
        for (n = 1; n <= 15; n++) begin
            wr(12'h04c + 12'(4 * n), 32'hff);
            x8 = n == 8 ? 8'h1f : n <= 7 ? 8'h83 | 8'(n << 2) : 8'h9f;
            rd(12'h04c + 12'(4 * n), 32'(x8));
        end
        wr(12'h0d8, 32'hffff);
        rd(12'h0d8, 32'hfffe);
        // unique pairs, programmed before any unmask
        wr(12'h070, 32'h0d);
        wr(12'h074, 32'h0e);
        wr(12'h07c, 32'h14);
        wr(12'h06c, 32'h02);
        @(posedge mclk) internal_request_bits <= 8'h02;
        tk(2);
        chk(32'(core_ipl), 32'h0);
        rd(12'h0e8, 32'h0200);
        wr(12'h0d8, 32'hf8fe);
        tk(1);
        chk(32'(core_ipl), 32'h3);
        @(posedge mclk) internal_request_bits <= 8'h06;
        tk(2);
        ack(4'ha, 1'b1, 8'h1b);
        @(posedge mclk) internal_request_bits <= 8'h16;
        wr(12'h0d8, 32'he8fe);
        tk(1);
        chk(32'(core_ipl), 32'h5);
        ack(4'hc, 1'b0, 8'h00);
        @(posedge mclk) internal_request_bits <= 8'h17;
        tk(2);
        chk(32'(core_ipl), 32'h7);
        ack(4'h8, 1'b0, 8'h0f);
        @(posedge mclk) internal_request_bits <= 8'h00;
        tk(2);
        chk(32'(core_ipl), 32'h0);
        // a pending, unmasked source at level zero must not reach the core
        wr(12'h080, 32'h00);
        wr(12'h0d8, 32'hc8fe);
        @(posedge mclk) internal_request_bits <= 8'h20;
        tk(2);
        chk(32'(core_ipl), 32'h0);
        // individual external inputs: level 2 ignored, level 4 served
        @(posedge mclk) ext_individual <= 1'b1;
        wr(12'h0d8, 32'hffea);
        @(posedge mclk) external_request_bits <= 7'h02;
        tk(2);
        chk(32'(core_ipl), 32'h0);
        @(posedge mclk) external_request_bits <= 7'h0a;
        tk(2);
        chk(32'(core_ipl), 32'h4);
        ack(4'h4, 1'b1, 8'h1c);
        @(posedge mclk) external_request_bits <= 7'h00;
        // freeze with each enable alone
        @(posedge mclk) debug_halt_mode <= 1'b1;
        tk(2);
        chk(32'({freeze_out, watchdog_halt, bus_monitor_halt}), 32'h7);
        wr(12'h00c, 32'h40);
        tk(1);
        chk(32'({freeze_out, watchdog_halt, bus_monitor_halt}), 32'h5);
        wr(12'h00c, 32'h80);
        tk(1);
        chk(32'({freeze_out, watchdog_halt, bus_monitor_halt}), 32'h6);
        @(posedge mclk) debug_halt_mode <= 1'b0;
        tk(2);
        chk(32'({freeze_out, watchdog_halt, bus_monitor_halt}), 32'h0);
        // no lock: bus kept until grant gone and cycle over
        @(posedge mclk) {bus_grant_in, bus_cycle_busy} <= 2'b11;
        tk(2);
        @(posedge mclk) bus_grant_in <= 1'b0;
        tk(2);
        chk(32'(bus_driven_out), 32'h1);
        @(posedge mclk) bus_cycle_busy <= 1'b0;
        tk(2);
        chk(32'(bus_driven_out), 32'h0);
        // lock held past grant until software clears it
        wr(12'h00c, 32'hff);
        rd(12'h00c, 32'he0);
        // low byte strobe off: the lock must survive the write
        pstrb <= 4'h0;
        wr(12'h00c, 32'h00);
        pstrb <= 4'hf;
        rd(12'h00c, 32'he0);
        @(posedge mclk) bus_grant_in <= 1'b1;
        tk(2);
        @(posedge mclk) bus_grant_in <= 1'b0;
        tk(3);
        chk(32'(bus_driven_out), 32'h1);
        wr(12'h00c, 32'h00);
        tk(2);
        chk(32'(bus_driven_out), 32'h0);
        wrap_up();
    end
endmodule
